/* design/tlg_pkg.sv */
package tlg_pkg;
  localparam int MASK_W = 16;
  localparam int ROW_W = 8;
  localparam int GROUP_W = 3;
  localparam logic [2:0] GRP_FIRST = 3'h1;
  localparam logic [2:0] GRP_LAST = 3'h6;
  localparam logic [2:0] GRP_RESET = 3'h1;

  localparam logic [2:0] SPT_N = 3'h0;
  localparam logic [2:0] SPT_Y = 3'h1;
  localparam logic [2:0] SPT_Y1 = 3'h2;

  localparam logic [2:0] ULO_N = 3'h0;
  localparam logic [2:0] ULO_1 = 3'h1;
  localparam logic [2:0] ULO_2 = 3'h2;
  localparam logic [2:0] ULO_3 = 3'h3;
  localparam logic [2:0] ULO_4 = 3'h4;

  localparam logic [5:0] ROW_FIRST = 6'h28;
  localparam logic [5:0] ROW_LAST_ONE = 6'h2d;
  localparam logic [5:0] ROW_LAST_TWO = 6'h30;

  localparam logic [3:0] ADDR_UNCOND_MASK = 4'h0;
  localparam logic [3:0] ADDR_SOTF_MASK = 4'h1;
  localparam logic [3:0] ADDR_COMM_MASK = 4'h2;
  localparam logic [3:0] ADDR_CONFIG = 4'h3;
  localparam logic [3:0] ADDR_GROUP_CMD = 4'h4;
  localparam logic [3:0] ADDR_DELAY = 4'h5;
  localparam logic [3:0] ADDR_DROPOUT = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_ROW_SEL = 4'h8;
  localparam logic [3:0] ADDR_ROW_DATA = 4'h9;

  localparam int CFG_SPT_LSB = 0;
  localparam int CFG_ULO_LSB = 4;
  localparam int CFG_TWO_BOARDS = 8;

  localparam int STEP_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int STEP_CYCLES = STEP_NS / CLK_NS;
  localparam logic [15:0] DELAY_RESET = 16'h000a;
  localparam logic [15:0] DROPOUT_RESET = 16'h0004;

  typedef enum logic [1:0] {
    GS_IDLE = 2'b00,
    GS_TIMING = 2'b01,
    GS_SWITCH = 2'b11
  } tlg_gs_type;
endpackage

/* design/tlg_row_mux.sv */
`timescale 1ns/1ps
module tlg_row_mux (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [5:0] rowSel,
  input wire logic twoBoards,
  input wire logic [31:0] outputs,
  input wire logic alarmN,
  input wire logic [15:0] inputs,
  input wire logic [7:0] peerTx,
  input wire logic [7:0] peerRx,
  input wire logic [7:0] chanStatus,
  output logic [7:0] rowData
);
  import tlg_pkg::*;
  typedef struct packed {
    logic [7:0] rowData;
  } tlg_row_state_type;
  tlg_row_state_type state;
  tlg_row_state_type next_state;
  logic [7:0] outLow;
  logic [7:0] outHigh;
  logic [7:0] outUp0;
  logic [7:0] outUp1;
  logic [7:0] txRev;
  logic [7:0] rxRev;
  logic [7:0] inLow;
  logic [7:0] inHigh;

  // Leftmost indicator sits in bit 7 in the output rows; input and peer rows keep input 0 in bit 0
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bits
      assign outLow[7 - i] = outputs[i];
      assign outUp0[7 - i] = outputs[16 + i];
      assign outUp1[7 - i] = outputs[24 + i];
      assign txRev[i] = peerTx[i];
      assign rxRev[i] = peerRx[i];
      assign inLow[i] = inputs[i];
      assign inHigh[i] = inputs[8 + i];
      if (i < 7) begin : g_out
        assign outHigh[7 - i] = outputs[8 + i];
      end else begin : g_alarm
        assign outHigh[0] = alarmN;
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.rowData = 8'h00;
    if (!twoBoards) begin
      case (rowSel)
        6'h28: next_state.rowData = outLow;
        6'h29: next_state.rowData = outHigh;
        6'h2a: next_state.rowData = txRev;
        6'h2b: next_state.rowData = chanStatus;
        6'h2c: next_state.rowData = inLow;
        6'h2d: next_state.rowData = rxRev;
        default: next_state.rowData = 8'h00;
      endcase
    end else begin
      case (rowSel)
        6'h28: next_state.rowData = outLow;
        6'h29: next_state.rowData = outHigh;
        6'h2a: next_state.rowData = outUp0;
        6'h2b: next_state.rowData = outUp1;
        6'h2c: next_state.rowData = txRev;
        6'h2d: next_state.rowData = chanStatus;
        6'h2e: next_state.rowData = inLow;
        6'h2f: next_state.rowData = inHigh;
        6'h30: next_state.rowData = rxRev;
        default: next_state.rowData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rowData = state.rowData;
endmodule

/* design/tlg_trip_logic.sv */
`timescale 1ns/1ps
// What this block does
// - Single-pole logic if enable setting is Y or Y1, or input asserted
// - Four trip outputs: three per-pole trips and one three-pole trip
// - Each per-pole output drives one breaker pole alone
// - Single-pole mode: zone 1 ground fault trips only faulted pole
// - Single-pole mode: zone 2 ground trips single pole only if scheme permits
// - Single-pole mode: per-phase direct trip trips its own pole
// - All other trips, including during a pole open, trip three poles
// - Three element masks: unconditional, onto-fault, comm scheme; OR of elements
// - Comm scheme mask trips only while permission is granted
// - Unlatch option: N timed dropout, 1 undercurrent, 2 aux, 3 both
// - Option 4 releases trip when external unlatch input asserts
// - Six setting groups stored, exactly one active
// - Select inputs decode binary, bit0 least significant, 1..6 pick groups
// - Select all low or all high uses the group command value
// - Unassigned select inputs count as zero
// - Group switches only after selection held for the programmed delay
// - Peer link break, framing, parity, overrun flagged separately
// - Peer idle excess, sync request, data error, disabled flagged
// - One board: status rows 40 to 45
// - Two boards: status rows 40 to 48 with extra outputs and inputs
module tlg_trip_logic #(
  parameter int MASK_W = tlg_pkg::MASK_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  input wire logic [MASK_W-1:0] elements,
  input wire logic [2:0] zone1Ground,
  input wire logic [2:0] zone2Ground,
  input wire logic commPermit,
  input wire logic sotfActive,
  input wire logic single_pole_trip_input,
  input wire logic direct_trip_phase_a,
  input wire logic direct_trip_phase_b,
  input wire logic direct_trip_phase_c,
  input wire logic single_pole_open,
  input wire logic underCurrent,
  input wire logic [2:0] breakerOpen,
  input wire logic external_unlatch_input,
  input wire logic group_select_bit0,
  input wire logic group_select_bit1,
  input wire logic group_select_bit2,
  input wire logic [2:0] selAssigned,
  input wire logic peer_link_break,
  input wire logic peer_link_framing_err,
  input wire logic peer_link_parity_err,
  input wire logic peer_link_overrun,
  input wire logic peer_link_idle_excess,
  input wire logic peer_link_sync_request,
  input wire logic peer_link_data_err,
  input wire logic peer_link_disabled,
  input wire logic [31:0] contactOutputs,
  input wire logic alarmN,
  input wire logic [15:0] contactInputs,
  input wire logic [7:0] peer_tx_bit,
  input wire logic [7:0] peer_rx_bit,
  output logic pole_a_trip,
  output logic pole_b_trip,
  output logic pole_c_trip,
  output logic three_pole_trip,
  output logic singlePoleMode,
  output logic [2:0] activeGroup
);
  import tlg_pkg::*;

  typedef struct packed {
    logic [MASK_W-1:0] uncondMask;
    logic [MASK_W-1:0] sotfMask;
    logic [MASK_W-1:0] commMask;
    logic [2:0] sptSetting;
    logic [2:0] unlatchOpt;
    logic twoBoards;
    logic [2:0] groupCmd;
    logic [15:0] delaySteps;
    logic [15:0] dropoutSteps;
    logic [5:0] rowSel;
    logic [2:0] poleTrip;
    logic threeTrip;
    logic [15:0] dropCnt;
    logic [6:0] stepCnt;
    logic [2:0] selSync1;
    logic [2:0] selSync2;
    logic [2:0] selSync3;
    logic [2:0] selStable;
    logic [2:0] candGroup;
    logic [15:0] grpCnt;
    tlg_gs_type gsState;
    logic [2:0] activeGroup;
    logic [31:0] rdData;
  } tlg_state_type;

  tlg_state_type state;
  tlg_state_type next_state;
  logic [7:0] rowData;
  logic [7:0] chanStatus;
  logic stepTick;
  logic spMode;
  logic [2:0] selRaw;
  logic [2:0] selDecoded;
  logic [2:0] spReq;
  logic tpReq;
  logic uncondHit;
  logic sotfHit;
  logic commHit;
  logic anyTrip;
  logic unlatchOk;

  assign chanStatus = {peer_link_break, peer_link_framing_err, peer_link_parity_err,
                       peer_link_overrun, peer_link_idle_excess, peer_link_sync_request,
                       peer_link_data_err, peer_link_disabled};

  tlg_row_mux u_rows (
    .core_clk(core_clk),
    .nrst(nrst),
    .rowSel(state.rowSel),
    .twoBoards(state.twoBoards),
    .outputs(contactOutputs),
    .alarmN(alarmN),
    .inputs(contactInputs),
    .peerTx(peer_tx_bit),
    .peerRx(peer_rx_bit),
    .chanStatus(chanStatus),
    .rowData(rowData)
  );

  // Processing-interval tick for the group and dropout timers
  assign stepTick = (state.stepCnt == 7'(STEP_CYCLES - 1));

  always_comb begin
    spMode = (state.sptSetting == SPT_Y) || (state.sptSetting == SPT_Y1)
             || single_pole_trip_input;
    uncondHit = |(elements & state.uncondMask);
    sotfHit = sotfActive && |(elements & state.sotfMask);
    commHit = commPermit && |(elements & state.commMask);
    spReq = 3'h0;
    tpReq = 1'b0;
    if (spMode && !single_pole_open) begin
      spReq = zone1Ground;
      spReq = spReq | (commPermit ? zone2Ground : 3'h0);
      spReq = spReq | {direct_trip_phase_c, direct_trip_phase_b, direct_trip_phase_a};
      // More than one pole faulted is no longer a single-line fault
      if ((spReq[0] + spReq[1] + spReq[2]) > 2'd1) begin
        tpReq = 1'b1;
        spReq = 3'h0;
      end
      tpReq = tpReq || uncondHit || sotfHit || commHit;
    end else begin
      tpReq = uncondHit || sotfHit || commHit || (|zone1Ground)
              || ((|zone2Ground) && commPermit)
              || direct_trip_phase_a || direct_trip_phase_b || direct_trip_phase_c;
    end
    anyTrip = tpReq || (|spReq);
    case (state.unlatchOpt)
      ULO_N: unlatchOk = (state.dropCnt == 16'h0000);
      ULO_1: unlatchOk = underCurrent;
      ULO_2: unlatchOk = &breakerOpen;
      ULO_3: unlatchOk = underCurrent && (&breakerOpen);
      ULO_4: unlatchOk = external_unlatch_input;
      default: unlatchOk = 1'b0;
    endcase
  end

  always_comb begin
    selRaw = {state.selSync3[2], state.selSync3[1], state.selSync3[0]};
    selRaw = (state.selSync2 == state.selSync3) ? state.selSync3 : state.selStable;
    selRaw = selRaw & selAssigned;
    if ((selRaw == 3'h0) || (selRaw == 3'h7)) begin
      selDecoded = state.groupCmd;
    end else begin
      selDecoded = selRaw;
    end
  end

  always_comb begin
    next_state = state;
    next_state.stepCnt = stepTick ? 7'h00 : state.stepCnt + 7'h01;
    next_state.selSync1 = {group_select_bit2, group_select_bit1, group_select_bit0};
    next_state.selSync2 = state.selSync1;
    next_state.selSync3 = state.selSync2;
    if (state.selSync2 == state.selSync3) begin
      next_state.selStable = state.selSync3;
    end

    // Trip latch: new trips add, release clears only when nothing is asking
    if (anyTrip) begin
      next_state.poleTrip = state.poleTrip | (tpReq ? 3'h7 : spReq);
      next_state.threeTrip = state.threeTrip | tpReq;
      next_state.dropCnt = state.dropoutSteps;
    end else if ((|state.poleTrip) && unlatchOk) begin
      next_state.poleTrip = 3'h0;
      next_state.threeTrip = 1'b0;
    end else if ((|state.poleTrip) && stepTick && (state.dropCnt != 16'h0000)) begin
      next_state.dropCnt = state.dropCnt - 16'h0001;
    end

    // Group selection; the active value is always one of the six groups
    case (state.gsState)
      GS_IDLE: begin
        if (selDecoded != state.activeGroup) begin
          next_state.candGroup = selDecoded;
          next_state.grpCnt = 16'h0000;
          next_state.gsState = GS_TIMING;
        end
      end
      GS_TIMING: begin
        if (selDecoded != state.candGroup) begin
          next_state.candGroup = selDecoded;
          next_state.grpCnt = 16'h0000;
          if (selDecoded == state.activeGroup) begin
            next_state.gsState = GS_IDLE;
          end
        end else if (state.grpCnt >= state.delaySteps) begin
          next_state.gsState = GS_SWITCH;
        end else if (stepTick) begin
          next_state.grpCnt = state.grpCnt + 16'h0001;
        end
      end
      GS_SWITCH: begin
        next_state.activeGroup = state.candGroup;
        next_state.gsState = GS_IDLE;
      end
      default: next_state.gsState = GS_IDLE;
    endcase

    next_state.rdData = 32'h0;
    if (wrStrobe) begin
      case (addr)
        ADDR_UNCOND_MASK: next_state.uncondMask = wrData[MASK_W-1:0];
        ADDR_SOTF_MASK: next_state.sotfMask = wrData[MASK_W-1:0];
        ADDR_COMM_MASK: next_state.commMask = wrData[MASK_W-1:0];
        ADDR_CONFIG: begin
          next_state.sptSetting = wrData[CFG_SPT_LSB +: 3];
          next_state.unlatchOpt = wrData[CFG_ULO_LSB +: 3];
          next_state.twoBoards = wrData[CFG_TWO_BOARDS];
        end
        ADDR_GROUP_CMD: begin
          // Out-of-range group numbers are ignored
          if ((wrData[2:0] >= GRP_FIRST) && (wrData[2:0] <= GRP_LAST)) begin
            next_state.groupCmd = wrData[2:0];
          end
        end
        ADDR_DELAY: next_state.delaySteps = wrData[15:0];
        ADDR_DROPOUT: next_state.dropoutSteps = wrData[15:0];
        ADDR_ROW_SEL: next_state.rowSel = wrData[5:0];
        default: next_state.rowSel = state.rowSel;
      endcase
    end
    if (rdStrobe) begin
      case (addr)
        ADDR_UNCOND_MASK: next_state.rdData = 32'(state.uncondMask);
        ADDR_SOTF_MASK: next_state.rdData = 32'(state.sotfMask);
        ADDR_COMM_MASK: next_state.rdData = 32'(state.commMask);
        ADDR_CONFIG: next_state.rdData = {23'h0, state.twoBoards, 1'b0, state.unlatchOpt,
                                          1'b0, state.sptSetting};
        ADDR_GROUP_CMD: next_state.rdData = {29'h0, state.groupCmd};
        ADDR_DELAY: next_state.rdData = {16'h0, state.delaySteps};
        ADDR_DROPOUT: next_state.rdData = {16'h0, state.dropoutSteps};
        ADDR_STATUS: next_state.rdData = {20'h0, state.activeGroup, spMode,
                                          state.threeTrip, state.poleTrip, chanStatus[7:6],
                                          2'b00};
        ADDR_ROW_SEL: next_state.rdData = {26'h0, state.rowSel};
        ADDR_ROW_DATA: next_state.rdData = {24'h0, rowData};
        default: next_state.rdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
      state.sptSetting <= SPT_N;
      state.unlatchOpt <= ULO_N;
      state.groupCmd <= GRP_RESET;
      state.activeGroup <= GRP_RESET;
      state.candGroup <= GRP_RESET;
      state.delaySteps <= DELAY_RESET;
      state.dropoutSteps <= DROPOUT_RESET;
      state.rowSel <= ROW_FIRST;
      state.gsState <= GS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign pole_a_trip = state.poleTrip[0];
  assign pole_b_trip = state.poleTrip[1];
  assign pole_c_trip = state.poleTrip[2];
  assign three_pole_trip = state.threeTrip;
  assign singlePoleMode = spMode;
  assign activeGroup = state.activeGroup;
  assign rdData = state.rdData;
endmodule

/* tb/tlg_breaker_model.sv */
`timescale 1ns/1ps
module tlg_breaker_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] poleTrip,
  input wire logic stuck,
  output logic [2:0] breakerOpen
);
  // Poles part three cycles after their own trip; a stuck breaker never parts
  logic [2:0] s1;
  logic [2:0] s2;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      breakerOpen <= 3'h0;
    end else begin
      s1 <= poleTrip & ~{3{stuck}};
      s2 <= s1;
      breakerOpen <= s2;
    end
  end
endmodule

/* tb/tlg_trip_logic_assertions.sv */
`timescale 1ns/1ps
module tlg_trip_logic_assertions #(
  parameter int MASK_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [31:0] rdData,
  input wire logic [MASK_W-1:0] elements,
  input wire logic [2:0] zone1Ground,
  input wire logic commPermit,
  input wire logic single_pole_trip_input,
  input wire logic single_pole_open,
  input wire logic pole_a_trip,
  input wire logic pole_b_trip,
  input wire logic pole_c_trip,
  input wire logic three_pole_trip,
  input wire logic singlePoleMode,
  input wire logic [2:0] activeGroup
);
  import tlg_pkg::*;
  // Shadow masks see writes only, so a zero reset value is assumed
  logic [MASK_W-1:0] uMask;
  logic [MASK_W-1:0] cMask;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      uMask <= '0;
      cMask <= '0;
    end else if (wrStrobe) begin
      if (addr == ADDR_UNCOND_MASK) uMask <= wrData[MASK_W-1:0];
      if (addr == ADDR_COMM_MASK) cMask <= wrData[MASK_W-1:0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  rd_idle_zero_a: assert property (!$past(rdStrobe) |-> rdData == 32'h0)
    else $error("read data not zero outside read");
  rd_unmapped_zero_a: assert property (rdStrobe && addr > ADDR_ROW_DATA |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  mask_trip_a: assert property (((elements & uMask) != '0) ||
    (commPermit && (elements & cMask) != '0) |=> three_pole_trip)
    else $error("masked element did not trip");
  three_all_a: assert property (three_pole_trip |->
    pole_a_trip && pole_b_trip && pole_c_trip)
    else $error("three-pole trip without all poles");
  sp_input_a: assert property (single_pole_trip_input |-> singlePoleMode)
    else $error("single-pole input ignored");
  tp_mode_a: assert property ($rose(pole_a_trip) && !$past(singlePoleMode) |->
    three_pole_trip)
    else $error("single pole trip in three-pole mode");
  zone1_pole_a: assert property (singlePoleMode && !single_pole_open &&
    zone1Ground == 3'h1 |=> pole_a_trip)
    else $error("zone 1 ground fault did not trip pole");
  spo_three_a: assert property (singlePoleMode && single_pole_open &&
    zone1Ground != 3'h0 |=> three_pole_trip)
    else $error("trip during pole open not three-pole");
  group_range_a: assert property (activeGroup >= GRP_FIRST && activeGroup <= GRP_LAST)
    else $error("active group out of range");
  trip3_c: cover property ($rose(three_pole_trip));
  trip1_c: cover property (pole_a_trip && !three_pole_trip);
  group_c: cover property ($changed(activeGroup));
  row_c: cover property (rdStrobe && addr == ADDR_ROW_DATA);
endmodule
bind tlg_trip_logic tlg_trip_logic_assertions #(.MASK_W(MASK_W)) chk_u (.*);

/* tb/test_trip_logic_group_select.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_trip_logic_group_select;
  import tlg_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [31:0] rdData;
  logic [15:0] elements = 16'h0;
  logic [2:0] z1 = 3'h0;
  logic [2:0] z2 = 3'h0;
  logic [2:0] dt = 3'h0;
  logic [3:0] fl = 4'h0;
  logic underCurrent = 1'b0;
  logic stuck = 1'b0;
  logic [2:0] brk;
  logic ext = 1'b0;
  logic [2:0] gsel = 3'h0;
  logic [2:0] asg = 3'h7;
  logic [7:0] ps = 8'hb1;
  logic [31:0] co = 32'h8421c3a5;
  logic [15:0] ci = 16'h5a3c;
  logic [7:0] tx = 8'h96;
  logic [7:0] rx = 8'h2d;
  logic alarmN = 1'b0;
  logic [3:0] trips;
  logic singlePoleMode;
  logic [2:0] activeGroup;
  logic [31:0] d;
  int n_errors = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  tlg_trip_logic dut_u (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .elements(elements),
    .zone1Ground(z1), .zone2Ground(z2), .commPermit(fl[3]), .sotfActive(fl[2]),
    .single_pole_open(fl[1]), .single_pole_trip_input(fl[0]), .direct_trip_phase_a(dt[0]),
    .direct_trip_phase_b(dt[1]), .direct_trip_phase_c(dt[2]), .underCurrent(underCurrent),
    .breakerOpen(brk), .external_unlatch_input(ext), .group_select_bit0(gsel[0]),
    .group_select_bit1(gsel[1]), .group_select_bit2(gsel[2]), .selAssigned(asg),
    .peer_link_break(ps[7]), .peer_link_framing_err(ps[6]), .peer_link_parity_err(ps[5]),
    .peer_link_overrun(ps[4]), .peer_link_idle_excess(ps[3]), .peer_link_sync_request(ps[2]),
    .peer_link_data_err(ps[1]), .peer_link_disabled(ps[0]), .contactOutputs(co),
    .alarmN(alarmN), .contactInputs(ci), .peer_tx_bit(tx), .peer_rx_bit(rx),
    .pole_a_trip(trips[0]), .pole_b_trip(trips[1]), .pole_c_trip(trips[2]),
    .three_pole_trip(trips[3]), .singlePoleMode(singlePoleMode), .activeGroup(activeGroup));
  tlg_breaker_model brk_u (.core_clk(core_clk), .nrst(nrst), .poleTrip(trips[2:0]),
    .stuck(stuck), .breakerOpen(brk));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    cyc(1);
    wrStrobe <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rdStrobe <= 1'b1;
    cyc(1);
    rdStrobe <= 1'b0;
    #1;
    v = rdData;
    cyc(1);
  endtask
  function automatic logic [31:0] cfg(logic [2:0] s, logic [2:0] u, int two);
    return {23'h0, two[0], 1'b0, u, 1'b0, s};
  endfunction
  function automatic logic [7:0] rev8(logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction
  // One board skips the extra output and input rows, so map onto the two-board table
  function automatic logic [7:0] expRow(int r, logic two);
    int k;
    k = (!two && r > 45) ? 0 : ((!two && r > 41) ? r + 2 + int'(r == 45) : r);
    case (k)
      40: return rev8(co[7:0]);
      41: return (rev8(co[15:8]) & 8'hfe) | {7'h0, alarmN};
      42: return rev8(co[23:16]);
      43: return rev8(co[31:24]);
      44: return tx;
      45: return ps;
      46: return ci[7:0];
      47: return ci[15:8];
      48: return rx;
      default: return 8'h0;
    endcase
  endfunction
  task automatic fire(input logic [3:0] e);
    cyc(1);
    elements <= 16'h0;
    {z1, z2, dt, fl} <= 13'h0;
    cyc(1);
    `CHK(trips, e)
  endtask
  task automatic tc(input logic [31:0] c, input logic [15:0] el, input logic [12:0] cause,
      input logic [3:0] e);
    wr(ADDR_CONFIG, c);
    elements <= el;
    {z1, z2, dt, fl} <= cause;
    fire(e);
    ext <= 1'b1;
    cyc(3);
    ext <= 1'b0;
    cyc(2);
    `CHK(trips, 4'h0)
  endtask
  task automatic ulc(input logic [2:0] u, input int s, input int un, input int e);
    wr(ADDR_CONFIG, cfg(SPT_N, u, 0));
    stuck <= s[0];
    underCurrent <= 1'b0;
    elements <= 16'h1;
    fire(4'hf);
    underCurrent <= un[0];
    cyc(20);
    `CHK(trips[3], e[0])
    stuck <= 1'b0;
    underCurrent <= 1'b1;
    cyc(20);
    `CHK(trips[3], 1'b0)
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    cyc(8);
    nrst <= 1'b1;
    cyc(1);
    `CHK(singlePoleMode, 1'b0)
    rd(ADDR_GROUP_CMD, d);
    `CHK(d, {29'h0, GRP_RESET})
    rd(ADDR_DELAY, d);
    `CHK(d, {16'h0, DELAY_RESET})
    rd(ADDR_DROPOUT, d);
    `CHK(d, {16'h0, DROPOUT_RESET})
    rd(ADDR_ROW_SEL, d);
    `CHK(d, {26'h0, ROW_FIRST})
    rd(4'hf, d);
    `CHK(d, 32'h0)
    $display("Test reset values done");
    wr(ADDR_UNCOND_MASK, 32'h81);
    wr(ADDR_SOTF_MASK, 32'h2);
    wr(ADDR_COMM_MASK, 32'h4);
    elements <= 16'h80;
    fire(4'hf);
    cyc(300);
    `CHK(trips[3], 1'b1)
    cyc(250);
    `CHK(trips[3], 1'b0)
    tc(cfg(SPT_N, ULO_4, 0), 16'h100, 13'h0, 4'h0);
    tc(cfg(SPT_N, ULO_4, 0), 16'h2, 13'h0, 4'h0);
    tc(cfg(SPT_N, ULO_4, 0), 16'h2, 13'h4, 4'hf);
    tc(cfg(SPT_N, ULO_4, 0), 16'h4, 13'h0, 4'h0);
    tc(cfg(SPT_N, ULO_4, 0), 16'h4, 13'h8, 4'hf);
    tc(cfg(SPT_N, ULO_4, 0), 16'h0, 13'h0400, 4'hf);
    tc(cfg(SPT_Y, ULO_4, 0), 16'h0, 13'h0400, 4'h1);
    tc(cfg(SPT_Y, ULO_4, 0), 16'h0, 13'h0080, 4'h0);
    tc(cfg(SPT_Y, ULO_4, 0), 16'h0, 13'h0108, 4'h2);
    tc(cfg(SPT_Y, ULO_4, 0), 16'h0, 13'h0040, 4'h4);
    tc(cfg(SPT_Y, ULO_4, 0), 16'h0, 13'h0402, 4'hf);
    tc(cfg(SPT_Y, ULO_4, 0), 16'h1, 13'h0, 4'hf);
    tc(cfg(SPT_Y1, ULO_4, 0), 16'h0, 13'h0800, 4'h2);
    tc(cfg(SPT_N, ULO_4, 0), 16'h0, 13'h0011, 4'h1);
    wr(ADDR_CONFIG, cfg(SPT_Y1, ULO_4, 0));
    `CHK(singlePoleMode, 1'b1)
    $display("Test trip logic done");
    ulc(ULO_1, 0, 0, 1);
    ulc(ULO_1, 0, 1, 0);
    ulc(ULO_2, 0, 0, 0);
    ulc(ULO_2, 1, 1, 1);
    ulc(ULO_3, 0, 0, 1);
    ulc(ULO_3, 1, 1, 1);
    ulc(ULO_3, 0, 1, 0);
    $display("Test unlatch done");
    wr(ADDR_DELAY, 32'h2);
    gsel <= 3'h3;
    cyc(150);
    `CHK(activeGroup, 3'h1)
    cyc(70);
    `CHK(activeGroup, 3'h3)
    gsel <= 3'h4;
    cyc(120);
    gsel <= 3'h5;
    cyc(150);
    `CHK(activeGroup, 3'h3)
    cyc(70);
    `CHK(activeGroup, 3'h5)
    wr(ADDR_GROUP_CMD, 32'h6);
    wr(ADDR_GROUP_CMD, 32'h7);
    rd(ADDR_GROUP_CMD, d);
    `CHK(d, 32'h6)
    gsel <= 3'h7;
    cyc(220);
    `CHK(activeGroup, 3'h6)
    asg <= 3'h3;
    cyc(220);
    `CHK(activeGroup, 3'h3)
    rd(ADDR_STATUS, d);
    `CHK(d[11:9], 3'h3)
    `CHK(d[3:2], ps[7:6])
    wr(ADDR_DROPOUT, 32'h3);
    rd(ADDR_DROPOUT, d);
    `CHK(d, 32'h3)
    $display("Test groups done");
    for (int t = 0; t < 2; t++) begin
      wr(ADDR_CONFIG, cfg(SPT_N, ULO_N, t));
      for (int r = 40; r < 47 + 2 * t; r++) begin
        wr(ADDR_ROW_SEL, 32'(r));
        rd(ADDR_ROW_DATA, d);
        `CHK(d[7:0], expRow(r, t[0]))
      end
    end
    $display("Test rows done");
    report_and_stop();
  end
endmodule
